// ### logic/cwps_pkg.sv
// Constants shared by both ends of the configuration word programming link
//
// Function
// [R1] Reset loads configuration registers from flash words
// [R2] Config registers change only by program plus reset
// [R3] Reset steps through each flash word in turn
// [R4] Programmer chip-erases before rewriting a programmed word; the programmer here never erases, only a power-on reset restores erased cells
// [R5] Programming only clears bits, never sets them
// [R6] Command and payload shifted least significant first
// [R7] Table page 00h or 01h by memory size
// [R8] Protection bits written one first, cleared later
// [R9] First word at last address, second two below
// [R10] Reserved top bit of first word written zero
// [R11] Start with no-op, jump to 0x200, no-op
// [R12] Control register set to 0x4003 before write
// [R13] Address split: page byte, write pointer low
// [R14] Table write latches value, bumps pointer, two no-ops
// [R15] Write bit starts write, cleared when done, polled
// [R16] Command 0001 shifts out visibility register
// [R17] Repeat load-to-reset steps for the first word
// [R18] Command 0000 executes payload, 0001 shifts out
// [R19] After each poll, jump 0x200 then no-op
package cwps_pkg;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int CMD_W = 4;
   localparam int INSTR_W = 24;
   localparam int FRAME_W = 28;
   localparam int VISI_W = 16;
   localparam logic [4:0] CMD_LAST = 5'h03;
   localparam logic [4:0] FRAME_LAST = 5'h1b;
   localparam logic [4:0] READ_LAST = 5'h13;
   localparam logic [4:0] READ_BITS = 5'h10;
   localparam logic [3:0] CMD_EXEC = 4'h0;
   localparam logic [3:0] CMD_SHIFT_OUT = 4'h1;
   // ----------------------------------------
   // Instruction payloads
   // ----------------------------------------
   localparam logic [23:0] OP_NOP = 24'h000000;
   localparam logic [23:0] OP_GOTO_200 = 24'h040200;
   localparam logic [23:0] OP_NVM_FROM_W10 = 24'h883b0a;
   localparam logic [23:0] OP_PAGE_FROM_W0 = 24'h880190;
   localparam logic [23:0] OP_TABLE_WRITE_LOW = 24'hbb1b86;
   localparam logic [23:0] OP_SET_WRITE = 24'ha8e761;
   localparam logic [23:0] OP_W2_FROM_NVM = 24'h803b02;
   localparam logic [23:0] OP_VISI_FROM_W2 = 24'h883c22;
   localparam logic [3:0] OP_MOV_LIT = 4'h2;
   localparam logic [3:0] W_PAGE = 4'h0;
   localparam logic [3:0] W_STATUS = 4'h2;
   localparam logic [3:0] W_DATA = 4'h6;
   localparam logic [3:0] W_PTR = 4'h7;
   localparam logic [3:0] W_NVM = 4'ha;
   // ----------------------------------------
   // Controller and configuration words
   // ----------------------------------------
   localparam logic [15:0] NVM_CFG_PROG = 16'h4003;
   localparam int NVM_WR_BIT = 15;
   localparam logic [15:0] CW1_RESET = 16'h7fff;
   localparam logic [15:0] CW2_RESET = 16'hffff;
   localparam logic [23:0] CW_ADDR_STEP = 24'h000002;
   localparam logic [23:0] CW1_ADDR_DEFAULT = 24'h00fffe;
   localparam logic [15:0] WRITE_BUSY_CYCLES = 16'h00c8;
   localparam logic [7:0] HALF_PERIOD_CYCLES = 8'h0a;
   // ----------------------------------------
   // Programmer sequence indices
   // ----------------------------------------
   localparam logic [4:0] IDX_LOAD_PTR = 5'h03;
   localparam logic [4:0] IDX_LOAD_DATA = 5'h08;
   localparam logic [4:0] IDX_POLL = 5'h10;
   localparam logic [4:0] IDX_READ = 5'h15;
   localparam logic [4:0] IDX_POLL_END = 5'h16;
   localparam logic [4:0] IDX_LAST = 5'h18;

   // Accept a synchronised level only once two stages agree
   function automatic logic agree(input logic s2, input logic s3, input logic lv);
      return (s2 == s3) ? s3 : lv;
   endfunction
endpackage

// ### logic/cwps_link_if.sv
// Serial programming link between the programmer and the device
`timescale 1ns/1ns
`default_nettype none
interface cwps_link_if;
   logic prog_clock_pin;
   logic host_data_out;
   logic host_data_oe;
   logic dev_data_out;
   logic dev_data_oe;
   logic prog_data_pin;
   // Resolved pin level; pulled high when nobody drives
   assign prog_data_pin = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 1'b1);
   modport device(input prog_clock_pin, input prog_data_pin,
                  output dev_data_out, output dev_data_oe);
   modport host(output prog_clock_pin, output host_data_out, output host_data_oe,
                input prog_data_pin);
endinterface
`default_nettype wire

// ### logic/cwps_device.sv
// Device end: serial command engine, nonvolatile controller, config words
`timescale 1ns/1ns
`default_nettype none
module cwps_device #(
   parameter logic [23:0] CW1_ADDR = cwps_pkg::CW1_ADDR_DEFAULT,
   parameter logic [15:0] WRITE_BUSY_CYCLES = cwps_pkg::WRITE_BUSY_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_power_on,
   // Programming link
   cwps_link_if.device link,
   // Configuration outputs and write busy flag
   output logic [15:0] o_config_word_one,
   output logic [15:0] o_config_word_two,
   output logic o_config_valid,
   output logic o_write_busy
);
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {PH_LOAD, PH_CMD, PH_DATA, PH_READ} cwps_phase_t;
   typedef enum logic [2:0] {
      EX_NONE, EX_MOV_LIT, EX_SET_NVM, EX_SET_PAGE, EX_TBLWT, EX_START, EX_GET_NVM,
      EX_SET_VISI
   } cwps_exec_t;

   typedef struct packed {
      cwps_phase_t ph;
      logic [2:0] clk_s;
      logic [2:0] dat_s;
      logic clk_lv;
      logic dat_lv;
      logic [27:0] sh;
      logic [4:0] cnt;
      logic [15:0][15:0] w;
      logic [15:0] nonvolatile_control_reg;
      logic [15:0] visi;
      logic [7:0] table_page_reg;
      logic [23:0] latch_addr;
      logic [15:0] latch;
      logic latch_ok;
      logic [15:0] busy;
      logic [1:0][15:0] cells;
      logic [1:0][15:0] cfg;
      logic load_idx;
      logic cfg_ok;
      logic dout;
      logic doe;
   } cwps_dev_state_t;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic cwps_exec_t decode(input logic [23:0] instr);
      if (instr[23:20] == cwps_pkg::OP_MOV_LIT) begin
         return EX_MOV_LIT;
      end
      unique case (instr)
         cwps_pkg::OP_NVM_FROM_W10: return EX_SET_NVM;
         cwps_pkg::OP_PAGE_FROM_W0: return EX_SET_PAGE;
         cwps_pkg::OP_TABLE_WRITE_LOW: return EX_TBLWT;
         cwps_pkg::OP_SET_WRITE: return EX_START;
         cwps_pkg::OP_W2_FROM_NVM: return EX_GET_NVM;
         cwps_pkg::OP_VISI_FROM_W2: return EX_SET_VISI;
         // No-op and the jump to 0x200 leave visible state alone
         default: return EX_NONE;
      endcase
   endfunction

   // Cell 0 is the first word at the top, cell 1 two addresses below
   function automatic logic [23:0] cell_addr(input int idx);
      return (idx == 0) ? CW1_ADDR : CW1_ADDR - cwps_pkg::CW_ADDR_STEP; // see [R9]
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   cwps_dev_state_t st;
   cwps_dev_state_t next_st;
   logic rise;
   logic fall;
   logic [23:0] instr;

   always_comb begin
      next_st = st;
      next_st.clk_s = {st.clk_s[1:0], link.prog_clock_pin};
      next_st.dat_s = {st.dat_s[1:0], link.prog_data_pin};
      next_st.clk_lv = cwps_pkg::agree(st.clk_s[1], st.clk_s[2], st.clk_lv);
      next_st.dat_lv = cwps_pkg::agree(st.dat_s[1], st.dat_s[2], st.dat_lv);
      rise = next_st.clk_lv & ~st.clk_lv;
      fall = ~next_st.clk_lv & st.clk_lv;
      instr = '0;

      // Write cycle; the busy bit is only dropped by the countdown
      if (st.nonvolatile_control_reg[cwps_pkg::NVM_WR_BIT]) begin
         if (st.busy == 16'h0000) begin
            if (st.latch_ok && st.nonvolatile_control_reg[14:0] == cwps_pkg::NVM_CFG_PROG[14:0]) begin
               for (int i = 0; i < 2; i++) begin
                  if (st.latch_addr == cell_addr(i)) begin
                     // Cells can only lose ones
                     next_st.cells[i] = st.cells[i] & st.latch; // see [R5]
                  end
               end
            end
            next_st.nonvolatile_control_reg[cwps_pkg::NVM_WR_BIT] = 1'b0; // see [R15]
            next_st.latch_ok = 1'b0;
         end else begin
            next_st.busy = st.busy - 16'h0001;
         end
      end

      unique case (st.ph)
         PH_LOAD: begin
            // Copy each flash cell into its register, one per cycle
            next_st.cfg[st.load_idx] = st.cells[st.load_idx]; // see [R1] [R3]
            next_st.load_idx = 1'b1;
            if (st.load_idx) begin
               next_st.ph = PH_CMD;
               next_st.cfg_ok = 1'b1;
            end
         end
         PH_CMD: begin
            if (rise) begin
               next_st.sh = {next_st.dat_lv, st.sh[27:1]}; // see [R6]
               next_st.cnt = st.cnt + 5'h01;
               if (st.cnt == cwps_pkg::CMD_LAST) begin
                  next_st.cnt = cwps_pkg::CMD_LAST + 5'h01;
                  // Unknown command codes are dropped silently
                  if (next_st.sh[27:24] == cwps_pkg::CMD_EXEC) begin
                     next_st.ph = PH_DATA; // see [R18]
                  end else if (next_st.sh[27:24] == cwps_pkg::CMD_SHIFT_OUT) begin
                     next_st.ph = PH_READ; // see [R16]
                     next_st.cnt = 5'h00;
                  end else begin
                     next_st.cnt = 5'h00;
                  end
               end
            end
         end
         PH_DATA: begin
            if (rise) begin
               next_st.sh = {next_st.dat_lv, st.sh[27:1]};
               next_st.cnt = st.cnt + 5'h01;
               if (st.cnt == cwps_pkg::FRAME_LAST) begin
                  next_st.cnt = 5'h00;
                  next_st.ph = PH_CMD;
                  instr = next_st.sh[27:4];
                  unique case (decode(instr)) // see [R18]
                     EX_MOV_LIT: begin
                        next_st.w[instr[3:0]] = instr[19:4];
                     end
                     EX_SET_NVM: begin
                        // Controller is locked while a write runs
                        if (!st.nonvolatile_control_reg[cwps_pkg::NVM_WR_BIT]) begin
                           next_st.nonvolatile_control_reg = {1'b0, st.w[cwps_pkg::W_NVM][14:0]};
                        end
                     end
                     EX_SET_PAGE: begin
                        next_st.table_page_reg = st.w[cwps_pkg::W_PAGE][7:0];
                     end
                     EX_TBLWT: begin
                        next_st.latch = st.w[cwps_pkg::W_DATA]; // see [R14]
                        next_st.latch_addr = {st.table_page_reg, st.w[cwps_pkg::W_PTR]};
                        next_st.latch_ok = 1'b1;
                        next_st.w[cwps_pkg::W_PTR] = st.w[cwps_pkg::W_PTR] + 16'h0002;
                     end
                     EX_START: begin
                        if (!st.nonvolatile_control_reg[cwps_pkg::NVM_WR_BIT]) begin
                           next_st.nonvolatile_control_reg[cwps_pkg::NVM_WR_BIT] = 1'b1; // see [R15]
                           next_st.busy = WRITE_BUSY_CYCLES - 16'h0001;
                        end
                     end
                     EX_GET_NVM: begin
                        next_st.w[cwps_pkg::W_STATUS] = st.nonvolatile_control_reg;
                     end
                     EX_SET_VISI: begin
                        next_st.visi = st.w[cwps_pkg::W_STATUS];
                     end
                     EX_NONE: begin
                     end
                  endcase
               end
            end
         end
         PH_READ: begin
            // Each rising edge puts the next bit on the pin
            if (rise && st.cnt < cwps_pkg::READ_BITS) begin
               next_st.dout = st.visi[st.cnt[3:0]]; // see [R16]
               next_st.doe = 1'b1;
               next_st.cnt = st.cnt + 5'h01;
            end else if (fall && st.cnt == cwps_pkg::READ_BITS) begin
               next_st.doe = 1'b0;
               next_st.dout = 1'b0;
               next_st.cnt = 5'h00;
               next_st.ph = PH_CMD;
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Flash cells survive an ordinary reset; only power-on erases them
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= '0;
         st.cells <= i_power_on ? {cwps_pkg::CW2_RESET, cwps_pkg::CW1_RESET} : st.cells;
      end else begin
         st <= next_st;
      end
   end

   // Config registers have no write path besides the reset load
   assign o_config_word_one = st.cfg[0]; // see [R2]
   assign o_config_word_two = st.cfg[1];
   assign o_config_valid = st.cfg_ok;
   assign o_write_busy = st.nonvolatile_control_reg[cwps_pkg::NVM_WR_BIT];
   assign link.dev_data_out = st.dout;
   assign link.dev_data_oe = st.doe;
endmodule
`default_nettype wire

// ### logic/cwps_programmer.sv
// Programmer end: drives the serial sequence that writes both config words
`timescale 1ns/1ns
`default_nettype none
module cwps_programmer #(
   parameter logic [7:0] HALF_PERIOD = cwps_pkg::HALF_PERIOD_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // User request
   input wire logic i_start,
   input wire logic [15:0] i_cw_one_value,
   input wire logic [15:0] i_cw_two_value,
   input wire logic [23:0] i_cw_two_addr,
   input wire logic [15:0] i_protect_mask,
   // Programming link
   cwps_link_if.host link,
   // Status
   output logic o_busy,
   output logic o_done,
   output logic [15:0] o_status
);
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {P_IDLE, P_GAP, P_LOW, P_HIGH} cwps_prog_phase_t;
   typedef struct packed {
      cwps_prog_phase_t ph;
      logic [7:0] div;
      logic [4:0] idx;
      logic [27:0] sh;
      logic [4:0] cnt;
      logic rd;
      logic wr;
      logic pass;
      logic word_sel;
      logic [15:0] visi;
      logic [2:0] dat_s;
      logic dat_lv;
      logic clk;
      logic dout;
      logic doe;
      logic busy;
      logic done;
      logic [15:0] cw1;
      logic [15:0] cw2;
      logic [23:0] addr;
      logic [15:0] mask;
   } cwps_prog_state_t;

   // ----------------------------------------
   // Sequence table, frame is {payload, command}
   // ----------------------------------------
   function automatic logic [27:0] frame_of(input logic [4:0] idx, input logic [23:0] addr,
                                            input logic [15:0] val);
      logic [23:0] op;
      op = cwps_pkg::OP_NOP;
      unique case (idx)
         5'h01, 5'h10, 5'h17: op = cwps_pkg::OP_GOTO_200; // see [R11] [R19]
         5'h03: op = {cwps_pkg::OP_MOV_LIT, addr[15:0], cwps_pkg::W_PTR}; // see [R13]
         5'h04: op = {cwps_pkg::OP_MOV_LIT, cwps_pkg::NVM_CFG_PROG, cwps_pkg::W_NVM};
         5'h05: op = cwps_pkg::OP_NVM_FROM_W10; // see [R12]
         5'h06: op = {cwps_pkg::OP_MOV_LIT, 8'h00, addr[23:16], cwps_pkg::W_PAGE};
         5'h07: op = cwps_pkg::OP_PAGE_FROM_W0; // see [R7]
         5'h08: op = {cwps_pkg::OP_MOV_LIT, val, cwps_pkg::W_DATA};
         5'h0a: op = cwps_pkg::OP_TABLE_WRITE_LOW; // see [R14]
         5'h0d: op = cwps_pkg::OP_SET_WRITE; // see [R15]
         5'h12: op = cwps_pkg::OP_W2_FROM_NVM;
         5'h13: op = cwps_pkg::OP_VISI_FROM_W2;
         default: op = cwps_pkg::OP_NOP;
      endcase
      if (idx == cwps_pkg::IDX_READ) begin
         return {24'h000000, cwps_pkg::CMD_SHIFT_OUT}; // see [R16]
      end
      return {op, cwps_pkg::CMD_EXEC};
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   cwps_prog_state_t st;
   cwps_prog_state_t next_st;
   logic tick;
   logic [15:0] val;
   logic [15:0] nvisi;
   logic [27:0] frame;

   always_comb begin
      next_st = st;
      next_st.dat_s = {st.dat_s[1:0], link.prog_data_pin};
      next_st.dat_lv = cwps_pkg::agree(st.dat_s[1], st.dat_s[2], st.dat_lv);
      next_st.done = 1'b0;
      tick = (st.div == 8'h00);
      next_st.div = tick ? HALF_PERIOD - 8'h01 : st.div - 8'h01;
      // Protection bits stay one on the first pass; reserved bit forced low
      val = st.word_sel ? st.cw1 : st.cw2;
      if (!st.pass) begin
         val = val | st.mask; // see [R8]
      end
      if (st.word_sel) begin
         val[15] = 1'b0; // see [R10]
      end
      frame = frame_of(st.idx, st.addr, val);
      nvisi = {st.dat_lv, st.visi[15:1]};

      unique case (st.ph)
         P_IDLE: begin
            if (i_start) begin
               next_st.cw1 = i_cw_one_value;
               next_st.cw2 = i_cw_two_value;
               next_st.addr = i_cw_two_addr;
               next_st.mask = i_protect_mask;
               next_st.idx = 5'h00;
               next_st.pass = 1'b0;
               next_st.word_sel = 1'b0;
               next_st.busy = 1'b1;
               next_st.ph = P_GAP;
               next_st.div = HALF_PERIOD - 8'h01;
            end
         end
         P_GAP: begin
            if (tick) begin
               next_st.sh = frame;
               next_st.rd = (frame[3:0] == cwps_pkg::CMD_SHIFT_OUT);
               next_st.cnt = 5'h00;
               next_st.dout = frame[0]; // see [R6]
               next_st.doe = 1'b1;
               next_st.ph = P_LOW;
            end
         end
         P_LOW: begin
            if (tick) begin
               next_st.clk = 1'b1;
               next_st.ph = P_HIGH;
            end
         end
         P_HIGH: begin
            if (tick) begin
               next_st.clk = 1'b0;
               if (st.rd && st.cnt > cwps_pkg::CMD_LAST) begin
                  next_st.visi = nvisi;
               end
               if (st.cnt == (st.rd ? cwps_pkg::READ_LAST : cwps_pkg::FRAME_LAST)) begin
                  next_st.doe = 1'b0;
                  next_st.ph = P_GAP;
                  next_st.idx = st.idx + 5'h01;
                  if (st.idx == cwps_pkg::IDX_READ) begin
                     next_st.wr = nvisi[cwps_pkg::NVM_WR_BIT];
                  end else if (st.idx == cwps_pkg::IDX_POLL_END && st.wr) begin
                     next_st.idx = cwps_pkg::IDX_POLL; // see [R15]
                  end else if (st.idx == cwps_pkg::IDX_LAST) begin
                     if (!st.word_sel) begin
                        next_st.word_sel = 1'b1;
                        next_st.idx = cwps_pkg::IDX_LOAD_DATA; // see [R17]
                     end else if (!st.pass && st.mask != 16'h0000) begin
                        next_st.pass = 1'b1;
                        next_st.word_sel = 1'b0;
                        next_st.idx = cwps_pkg::IDX_LOAD_PTR;
                     end else begin
                        next_st.ph = P_IDLE;
                        next_st.busy = 1'b0;
                        next_st.done = 1'b1;
                     end
                  end
               end else begin
                  next_st.cnt = st.cnt + 5'h01;
                  next_st.sh = {1'b0, st.sh[27:1]};
                  next_st.dout = st.sh[1];
                  // Release the pin while the device shifts out
                  next_st.doe = !(st.rd && st.cnt >= cwps_pkg::CMD_LAST);
                  next_st.ph = P_LOW;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_busy = st.busy;
   assign o_done = st.done;
   assign o_status = st.visi;
   assign link.prog_clock_pin = st.clk;
   assign link.host_data_out = st.dout;
   assign link.host_data_oe = st.doe;
endmodule
`default_nettype wire

// ### tb/cwps_link_properties.sv
// Concurrent checks on the serial programming link between both ends
`timescale 1ns/1ns
`default_nettype none
module cwps_link_properties (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Link signals
   input wire logic prog_clock_pin,
   input wire logic host_data_out,
   input wire logic host_data_oe,
   input wire logic dev_data_out,
   input wire logic dev_data_oe,
   input wire logic prog_data_pin
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // Masks the first sample, where $past still sees the start value
   logic armed = 1'b0;
   always @(posedge i_clk) begin
      armed <= 1'b1;
   end
   // ----------------------------------------
   // Clock edge shapes
   // ----------------------------------------
   sequence s_rise;
      !prog_clock_pin ##1 prog_clock_pin;
   endsequence
   sequence s_fall;
      prog_clock_pin ##1 !prog_clock_pin;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_single_driver: assert property (!(dev_data_oe && host_data_oe))
      else $error("both ends drive the data pin");
   a_host_data_steady: assert property (prog_clock_pin && $past(prog_clock_pin)
      |-> $stable(host_data_out)) else $error("programmer data moved while clock high");
   a_dev_data_steady: assert property (!prog_clock_pin && !$past(prog_clock_pin)
      && dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data_out))
      else $error("device data moved while clock low");
   a_clock_high_len: assert property (s_rise |-> prog_clock_pin [*8])
      else $error("link clock high phase too short");
   a_clock_low_len: assert property (s_fall |-> !prog_clock_pin [*8])
      else $error("link clock low phase too short");
   a_readout_len: assert property ($rose(dev_data_oe) |-> dev_data_oe [*8])
      else $error("device readout released too early");
   a_readout_on_rise: assert property ($rose(dev_data_oe) |-> prog_clock_pin)
      else $error("device drove data outside a high clock phase");
   a_pin_follows: assert property (dev_data_oe |-> prog_data_pin == dev_data_out)
      else $error("data pin does not follow device");
   a_idle_pullup: assert property (!dev_data_oe && !host_data_oe |-> prog_data_pin)
      else $error("released data pin not high");
   // Reset must leave the link quiet, so checked without the default disable
   a_reset_quiet: assert property (disable iff (1'b0) armed && $past(i_reset)
      |-> !prog_clock_pin && !dev_data_oe && !host_data_oe)
      else $error("link not released in reset");
   cover property (s_rise ##[1:40] $rose(dev_data_oe));
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench joining programmer and device over the link
`timescale 1ns/1ns
`default_nettype none
module tb;
   typedef struct packed {
      logic [15:0] v1;
      logic [15:0] v2;
      logic [15:0] m;
      logic [23:0] a;
      logic [15:0] e1;
      logic [15:0] e2;
   } cwps_row_t;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic i_power_on = 1'b1;
   logic i_start = 1'b0;
   logic [15:0] cw1 = 16'h0000;
   logic [15:0] cw2 = 16'h0000;
   logic [15:0] mask = 16'h0000;
   logic [23:0] addr = 24'h000000;
   logic [15:0] o_config_word_one;
   logic [15:0] o_config_word_two;
   logic o_config_valid;
   logic o_write_busy;
   logic o_busy;
   logic o_done;
   logic [15:0] o_status;
   int num_errors = 0;
   int compares = 0;
   cwps_row_t rows [3];
   cwps_link_if link();
   cwps_device #(.WRITE_BUSY_CYCLES(16'h0008)) cwps_device_inst (.i_clk(i_clk),
      .i_reset(i_reset), .i_power_on(i_power_on), .link(link),
      .o_config_word_one(o_config_word_one), .o_config_word_two(o_config_word_two),
      .o_config_valid(o_config_valid), .o_write_busy(o_write_busy));
   cwps_programmer #(.HALF_PERIOD(8'h09)) cwps_programmer_inst (.i_clk(i_clk),
      .i_reset(i_reset), .i_start(i_start), .i_cw_one_value(cw1), .i_cw_two_value(cw2),
      .i_cw_two_addr(addr), .i_protect_mask(mask), .link(link), .o_busy(o_busy),
      .o_done(o_done), .o_status(o_status));
   cwps_link_properties props_inst (.i_clk(i_clk), .i_reset(i_reset),
      .prog_clock_pin(link.prog_clock_pin), .host_data_out(link.host_data_out),
      .host_data_oe(link.host_data_oe), .dev_data_out(link.dev_data_out),
      .dev_data_oe(link.dev_data_oe), .prog_data_pin(link.prog_data_pin));
   always #25 i_clk = ~i_clk;
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic do_reset(input logic pwr);
      i_reset <= 1'b1;
      i_power_on <= pwr;
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      i_power_on <= 1'b0;
      repeat (4) @(posedge i_clk);
      check("config valid", {23'h0, o_config_valid}, 24'h1);
   endtask
   task automatic run_prog(input cwps_row_t r);
      int n;
      @(posedge i_clk);
      i_start <= 1'b1;
      cw1 <= r.v1;
      cw2 <= r.v2;
      mask <= r.m;
      addr <= r.a;
      @(posedge i_clk);
      i_start <= 1'b0;
      @(posedge i_clk);
      check("busy", {23'h0, o_busy}, 24'h1);
      for (n = 0; n < 60000 && o_done !== 1'b1; n++) begin
         @(posedge i_clk);
      end
      check("done seen", {23'h0, o_done}, 24'h1);
      check("final status", {8'h0, o_status}, {8'h0, cwps_pkg::NVM_CFG_PROG});
      check("write busy", {23'h0, o_write_busy}, 24'h0);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [15:0] p1;
      logic [15:0] p2;
      // Plain write, protection pass, then a miss on the cell address
      rows[0] = {16'h1234, 16'habcd, 16'h0000, 24'h00fffc, 16'h1234, 16'habcd};
      rows[1] = {16'hf0f0, 16'h0ff0, 16'h00ff, 24'h00fffc, 16'h1030, 16'h0bc0};
      rows[2] = {16'h0000, 16'h0000, 16'h0000, 24'h00fff0, 16'h1030, 16'h0bc0};
      do_reset(1'b1);
      check("erased one", {8'h0, o_config_word_one}, {8'h0, cwps_pkg::CW1_RESET});
      check("erased two", {8'h0, o_config_word_two}, {8'h0, cwps_pkg::CW2_RESET});
      p1 = cwps_pkg::CW1_RESET;
      p2 = cwps_pkg::CW2_RESET;
      for (int r = 0; r < 3; r++) begin
         run_prog(rows[r]);
         check("held one", {8'h0, o_config_word_one}, {8'h0, p1});
         check("held two", {8'h0, o_config_word_two}, {8'h0, p2});
         do_reset(1'b0);
         check("word one", {8'h0, o_config_word_one}, {8'h0, rows[r].e1});
         check("word two", {8'h0, o_config_word_two}, {8'h0, rows[r].e2});
         p1 = rows[r].e1;
         p2 = rows[r].e2;
      end
      // Second plain reset must reload the same cells unchanged
      do_reset(1'b0);
      check("reload one", {8'h0, o_config_word_one}, {8'h0, p1});
      check("reload two", {8'h0, o_config_word_two}, {8'h0, p2});
      conclude();
   end
   // Three rows take near 84k cycles; a hang is cut off before 100k
   initial begin
      #(95000 * 50);
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
